// *** design/ring_qual_pkg.sv ***
// Purpose: Shared constants for the ring validation qualifier
// Assumes: 40 MHz system clock
// Notes: Register offsets, field positions, reset values and time units
`default_nettype none
package ring_qual_pkg;

  // ----------------------------------------
  // Clock and time units
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DELAY_UNIT_MS = 256;
  localparam int unsigned TIMEOUT_UNIT_MS = 128;
  localparam int unsigned QUAL_UNIT_MS = 2;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_TIMING = 8'h17;
  localparam logic [7:0] ADDR_ENABLE_ASSERT = 8'h18;
  localparam logic [7:0] RESET_TIMING = 8'h2d;
  localparam logic [7:0] RESET_ENABLE_ASSERT = 8'h19;

  // Timing register fields
  localparam int unsigned DELAY_HI_BIT = 7;
  localparam int unsigned TIMEOUT_LSB = 3;
  localparam int unsigned TIMEOUT_W = 4;
  localparam int unsigned CONFIRM_LSB = 0;
  localparam int unsigned CONFIRM_W = 3;

  // Enable/assert register fields
  localparam int unsigned ENABLE_BIT = 7;
  localparam int unsigned RESERVED_BIT = 6;
  localparam int unsigned ASSERT_LSB = 0;
  localparam int unsigned ASSERT_W = 6;

  localparam int unsigned MS_W = 11;

  // ----------------------------------------
  // Qualifier states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONFIRM = 2'b01,
    ST_DELAY = 2'b10,
    ST_VALID = 2'b11
  } qual_state_t;

endpackage
`default_nettype wire

// *** design/tick_divider.sv ***
// Purpose: Divides the system clock into a one-cycle enable pulse
// Assumes: Single clock domain
// Notes: Pulse period is PERIOD cycles
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int unsigned PERIOD = 40000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Enable pulse
  output logic tick
);

  localparam int unsigned CW = $clog2(PERIOD);

  // Refuse periods that cannot make a one-cycle pulse
  if (PERIOD < 2) begin : g_period_check
    $error("tick_divider: PERIOD must be at least 2");
  end

  logic [CW-1:0] count;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == CW'(PERIOD - 1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** design/ring_validation_qualifier.sv ***
// Purpose: Qualifies line ring events by timing and confirms valid rings
// Assumes: ring_event is a one-cycle pulse synchronous to sys_clk
// Notes: Register port is a simple strobed write/read at the register offsets
//
// Contract
// - The valid-ring indication is held off after validation by 0 to 1792 ms in 256 ms steps.
// - A ring ends once the 4-bit timeout code times 128 ms passes after the last event.
// - A ring is valid only after staying in tolerance for the selected confirmation time.
// - Validation runs only while the enable bit 7 is set.
// - Each event loads the qualification timer with the assertion time, which counts down.
// - A later event after the timer expired marks the ring too slow and invalid.
// - Assertion time minus upper limit is the least event spacing in 2 ms units.
// - A later event while the timer exceeds the upper limit marks the ring too fast.
`timescale 1ns/1ps
`default_nettype none
module ring_validation_qualifier #(
  parameter int unsigned TICK_CYCLES = ring_qual_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Fields held in the neighbouring register
  input wire logic [1:0] ring_indicate_delay_low,
  input wire logic [5:0] ring_upper_limit,
  // Line side
  input wire logic ring_event,
  // Indications
  output logic ring_valid,
  output logic ring_invalid,
  output logic ring_active
);

  // Refuse a time base too short for the divider
  if (TICK_CYCLES < 2) begin : g_tick_check
    $error("ring_validation_qualifier: TICK_CYCLES must be at least 2");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] timing_reg;
  logic [7:0] enable_assert_reg;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      timing_reg <= ring_qual_pkg::RESET_TIMING;
      enable_assert_reg <= ring_qual_pkg::RESET_ENABLE_ASSERT;
    end else if (reg_wr) begin
      if (reg_addr == ring_qual_pkg::ADDR_TIMING) begin
        timing_reg <= reg_wdata;
      end
      if (reg_addr == ring_qual_pkg::ADDR_ENABLE_ASSERT) begin
        enable_assert_reg <= reg_wdata;
        // Reserved bit kept at zero
        enable_assert_reg[ring_qual_pkg::RESERVED_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ring_qual_pkg::ADDR_TIMING: begin
          reg_rdata <= timing_reg;
        end
        ring_qual_pkg::ADDR_ENABLE_ASSERT: begin
          reg_rdata <= enable_assert_reg;
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  logic enable;
  logic [5:0] assert_time;
  logic [3:0] timeout_code;
  logic [2:0] confirm_code;
  logic [2:0] delay_code;

  assign enable = enable_assert_reg[ring_qual_pkg::ENABLE_BIT];
  assign assert_time = enable_assert_reg[ring_qual_pkg::ASSERT_LSB +: ring_qual_pkg::ASSERT_W];
  assign timeout_code = timing_reg[ring_qual_pkg::TIMEOUT_LSB +: ring_qual_pkg::TIMEOUT_W];
  assign confirm_code = timing_reg[ring_qual_pkg::CONFIRM_LSB +: ring_qual_pkg::CONFIRM_W];
  assign delay_code = {timing_reg[ring_qual_pkg::DELAY_HI_BIT], ring_indicate_delay_low};

  // Confirmation time in ms
  function automatic logic [ring_qual_pkg::MS_W-1:0] confirm_ms(input logic [2:0] code);
    case (code)
      3'h0: confirm_ms = 11'h064;
      3'h1: confirm_ms = 11'h096;
      3'h2: confirm_ms = 11'h0c8;
      3'h3: confirm_ms = 11'h100;
      3'h4: confirm_ms = 11'h180;
      3'h5: confirm_ms = 11'h200;
      3'h6: confirm_ms = 11'h280;
      default: confirm_ms = 11'h400;
    endcase
  endfunction

  logic [ring_qual_pkg::MS_W-1:0] confirm_limit;
  logic [ring_qual_pkg::MS_W-1:0] delay_limit;
  logic [ring_qual_pkg::MS_W-1:0] timeout_limit;

  assign confirm_limit = confirm_ms(confirm_code);
  assign delay_limit = ring_qual_pkg::MS_W'(delay_code * ring_qual_pkg::DELAY_UNIT_MS);
  assign timeout_limit = ring_qual_pkg::MS_W'(timeout_code * ring_qual_pkg::TIMEOUT_UNIT_MS);

  // ----------------------------------------
  // Time base
  // ----------------------------------------
  logic ms_tick;
  logic half_phase;
  logic qual_tick;

  tick_divider #(
    .PERIOD(TICK_CYCLES)
  ) u_ms_tick (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tick(ms_tick)
  );

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      half_phase <= 1'b0;
    end else if (ms_tick) begin
      half_phase <= ~half_phase;
    end
  end

  // Qualification timer steps every 2 ms
  assign qual_tick = ms_tick && half_phase;

  // ----------------------------------------
  // Qualification timer and frequency checks
  // ----------------------------------------
  ring_qual_pkg::qual_state_t state;
  logic [5:0] qual_timer;
  logic too_slow;
  logic too_fast;
  logic bad_event;

  assign too_slow = (qual_timer == 6'h00);
  assign too_fast = (qual_timer > ring_upper_limit);
  assign bad_event = ring_event && (state != ring_qual_pkg::ST_IDLE) && (too_slow || too_fast);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      qual_timer <= 6'h00;
    end else if (!enable) begin
      qual_timer <= 6'h00;
    end else if (ring_event) begin
      qual_timer <= assert_time;
    end else if (qual_tick && qual_timer != 6'h00) begin
      qual_timer <= qual_timer - 1'b1;
    end
  end

  // ----------------------------------------
  // Time since last event
  // ----------------------------------------
  logic [ring_qual_pkg::MS_W-1:0] since_event;
  logic timed_out;

  assign timed_out = (since_event >= timeout_limit);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      since_event <= '0;
    end else if (!enable || ring_event) begin
      since_event <= '0;
    end else if (ms_tick && !timed_out) begin
      since_event <= since_event + 1'b1;
    end
  end

  // ----------------------------------------
  // Confirmation and delay sequencing
  // ----------------------------------------
  logic [ring_qual_pkg::MS_W-1:0] phase_ms;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ring_qual_pkg::ST_IDLE;
      phase_ms <= '0;
    end else if (!enable) begin
      state <= ring_qual_pkg::ST_IDLE;
      phase_ms <= '0;
    end else if (bad_event) begin
      state <= ring_qual_pkg::ST_CONFIRM;
      phase_ms <= '0;
    end else if (state != ring_qual_pkg::ST_IDLE && !ring_event && timed_out) begin
      state <= ring_qual_pkg::ST_IDLE;
      phase_ms <= '0;
    end else begin
      case (state)
        ring_qual_pkg::ST_IDLE: begin
          if (ring_event) begin
            state <= ring_qual_pkg::ST_CONFIRM;
            phase_ms <= '0;
          end
        end
        ring_qual_pkg::ST_CONFIRM: begin
          if (phase_ms >= confirm_limit) begin
            state <= ring_qual_pkg::ST_DELAY;
            phase_ms <= '0;
          end else if (ms_tick) begin
            phase_ms <= phase_ms + 1'b1;
          end
        end
        ring_qual_pkg::ST_DELAY: begin
          if (phase_ms >= delay_limit) begin
            state <= ring_qual_pkg::ST_VALID;
            phase_ms <= '0;
          end else if (ms_tick) begin
            phase_ms <= phase_ms + 1'b1;
          end
        end
        ring_qual_pkg::ST_VALID: begin
          phase_ms <= '0;
        end
        default: begin
          state <= ring_qual_pkg::ST_IDLE;
          phase_ms <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ring_valid <= 1'b0;
      ring_invalid <= 1'b0;
      ring_active <= 1'b0;
    end else begin
      ring_valid <= enable && (state == ring_qual_pkg::ST_VALID) && !bad_event
        && !(timed_out && !ring_event);
      ring_invalid <= enable && bad_event;
      ring_active <= enable && (state != ring_qual_pkg::ST_IDLE);
    end
  end

endmodule
`default_nettype wire

// *** sim/ring_qual_chk.sv ***
// Purpose: Port checker for the ring qualifier
// Assumes: Timeout code is never written as zero
// Notes: Enable and timeout code are tracked from register writes
`timescale 1ns/1ps
`default_nettype none
module ring_qual_chk #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Neighbour fields
  input wire logic [1:0] ring_indicate_delay_low,
  input wire logic [5:0] ring_upper_limit,
  // Line side and indications
  input wire logic ring_event,
  input wire logic ring_valid,
  input wire logic ring_invalid,
  input wire logic ring_active
);
  localparam int TK = TICK_CYCLES;
  logic en_q;
  logic [3:0] to_code;
  logic [15:0] gap;
  logic [15:0] act;
  int t_to;
  assign t_to = int'(to_code) * 128 * TK;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 1'b0;
      to_code <= 4'h5;
    end else if (reg_wr && reg_addr == 8'h18) begin
      en_q <= reg_wdata[7];
    end else if (reg_wr && reg_addr == 8'h17) begin
      to_code <= reg_wdata[6:3];
    end
  end
  // Cycles since the last event
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) gap <= 16'hffff;
    else if (ring_event) gap <= 16'h0;
    else if (gap != 16'hffff) gap <= gap + 16'h1;
  end
  // Cycles of unbroken qualification
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) act <= 16'h0;
    else if (!ring_active || ring_invalid) act <= 16'h0;
    else if (act != 16'hffff) act <= act + 16'h1;
  end
  a_event_starts_ring: assert property (
    en_q && ring_event |-> ##2 ring_active) else $error("ring not started");
  a_disabled_quiet: assert property (
    !en_q |=> !ring_active && !ring_valid) else $error("active while disabled");
  a_valid_in_ring: assert property (
    ring_valid |-> ring_active) else $error("valid outside ring");
  a_confirm_not_early: assert property (
    $rose(ring_valid) |-> int'(act) >= 96 * TK) else $error("valid too early");
  a_invalid_has_cause: assert property (
    ring_invalid |-> $past(ring_event)) else $error("invalid without event");
  a_invalid_drops_valid: assert property (
    ring_invalid |=> !ring_valid) else $error("valid kept");
  a_end_not_early: assert property (
    $fell(ring_active) && $past(en_q) |-> int'(gap) + 2 * TK >= t_to)
    else $error("ring ended early");
  a_end_not_late: assert property (
    ring_active |-> int'(gap) <= t_to + 3 * TK) else $error("ring ended late");
  a_spare_bit_zero: assert property (
    reg_rd && reg_addr == 8'h18 |=> !reg_rdata[6]) else $error("bit 6 set");
  c_valid: cover property ($rose(ring_valid));
  c_invalid: cover property (ring_invalid);
  c_end: cover property ($fell(ring_active));
endmodule
bind ring_validation_qualifier ring_qual_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .ring_indicate_delay_low(ring_indicate_delay_low), .ring_upper_limit(ring_upper_limit),
  .ring_event(ring_event), .ring_valid(ring_valid), .ring_invalid(ring_invalid),
  .ring_active(ring_active));
`default_nettype wire

// *** sim/ring_line.sv ***
// Purpose: Line-side threshold detector model
// Assumes: Caller sets the spacing of events
// Notes: Each event is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module ring_line (
  // Clock
  input wire logic sys_clk,
  // Event out
  output logic ring_event
);
  initial ring_event = 1'b0;
  task automatic pulse();
    @(posedge sys_clk);
    ring_event <= 1'b1;
    @(posedge sys_clk);
    ring_event <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_ring_validation_qualifier.sv ***
// Purpose: Bench for the ring qualifier
// Assumes: TICK_CYCLES of 4, so 1 ms is 4 cycles
// Notes: Events 40 ms apart stay within tolerance
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("Error %0t got %h exp %h", $time, a, e); end end
module tb_ring_validation_qualifier;
  logic sys_clk, reset_n, reg_wr, reg_rd, ring_event, ring_valid, ring_invalid, ring_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] dly;
  logic [5:0] upper;
  int bad_count, cmp_count, cyc, t_ev, t_rise, t_fall, c0, d, ms;
  logic vd, ad;
  int conf_ms[8] = '{100, 150, 200, 256, 384, 512, 640, 1024};
  int to_c[8] = '{1, 2, 15, 1, 3, 1, 7, 1};
  ring_validation_qualifier #(.TICK_CYCLES(4)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .ring_indicate_delay_low(dly), .ring_upper_limit(upper),
    .ring_event(ring_event), .ring_valid(ring_valid), .ring_invalid(ring_invalid),
    .ring_active(ring_active));
  ring_line u_line (.sys_clk(sys_clk), .ring_event(ring_event));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    vd <= ring_valid;
    ad <= ring_active;
    if (ring_valid && !vd) t_rise <= cyc;
    if (!ring_active && ad) t_fall <= cyc;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic ev();
    u_line.pulse();
    t_ev = cyc;
  endtask
  task automatic gap(input int n);
    repeat (n * 4 - 2) @(posedge sys_clk);
  endtask
  // Events 40 ms apart keep the ring in tolerance
  task automatic run_ok(input int n);
    repeat (n) begin
      gap(40);
      ev();
    end
  endtask
  function automatic bit near(input int a, input int b);
    return a >= b - 12 && a <= b + 12;
  endfunction
  task automatic wait_end(input int n);
    for (int k = 0; k < n * 512 + 60 && ring_active === 1'b1; k++) @(posedge sys_clk);
    @(posedge sys_clk);
    #1 `CHK(near(t_fall - t_ev, n * 512), 1'b1)
    `CHK(ring_valid, 1'b0)
  endtask
  task automatic finish_test();
    $display("Mismatches %0d, comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    dly = 2'b00;
    upper = 6'h0a;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h17, 8'h2d);
    rd(8'h18, 8'h19);
    rd(8'h20, 8'h00);
    ev();
    @(posedge sys_clk);
    #1 `CHK(ring_active, 1'b0)
    wr(8'h18, 8'h99);
    rd(8'h18, 8'h99);
    for (int i = 0; i < 8; i++) begin
      d = i % 4;
      ms = conf_ms[i] + (d == 3 ? 1792 : d * 256);
      wr(8'h17, {d == 3, to_c[i][3:0], i[2:0]});
      dly <= d[1:0];
      t_rise = 0;
      ev();
      c0 = t_ev;
      run_ok((ms + 60) / 40);
      `CHK(near(t_rise - c0, ms * 4), 1'b1)
      wait_end(to_c[i]);
    end
    wr(8'h17, 8'h08);
    dly <= 2'b00;
    ev();
    run_ok(4);
    `CHK(ring_valid, 1'b1)
    gap(10);
    ev();
    #1 `CHK(ring_invalid, 1'b1)
    c0 = t_ev;
    t_rise = 0;
    @(posedge sys_clk);
    #1 `CHK(ring_valid, 1'b0)
    run_ok(4);
    `CHK(near(t_rise - c0, 400), 1'b1)
    gap(60);
    ev();
    #1 `CHK(ring_invalid, 1'b1)
    // A higher upper limit lets the same 10 ms spacing pass
    @(posedge sys_clk);
    upper <= 6'h16;
    gap(10);
    ev();
    #1 `CHK(ring_invalid, 1'b0)
    wr(8'h18, 8'h19);
    @(posedge sys_clk);
    #1 `CHK(ring_active, 1'b0)
    finish_test();
  end
endmodule
`default_nettype wire
